// ==== bcc_combiner.sv ====
// Purpose: combine up to 30 configurable condition terms by AND or OR
// Assumes: all inputs synchronous to clk_sys_in except raw_input_bits_in
// Notes: result registered once; outputs follow one cycle after evaluation
`include "bcc_regs.svh"
// Overview of operation
// - result is all-terms-true in AND mode, any-term-true in OR mode
// - one mode bit governs the whole list; no mixing
// - up to 30 terms; unused slots are neutral
// - each term has an invert bit that complements its source
// - outputs with logic-result function follow the combined result
// - sources are inputs, outputs, warnings/locks, internal states
// - analogue threshold flags are selectable boolean sources
// - internal states include seven consecutive engine-sequence phase flags
module bcc_combiner
   import bcc_pkg::*;
#(
   parameter int NUM_TERMS = `BCC_MAX_TERMS,
   parameter int NUM_OUTPUTS = 16,
   parameter int SRC_BITS = 256
) (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic mode_or_in,
   input wire logic [NUM_TERMS-1:0] term_enable_in,
   input wire logic [NUM_TERMS*`BCC_SRC_W-1:0] term_class_in,
   input wire logic [NUM_TERMS*`BCC_SEL_W-1:0] term_index_in,
   input wire logic [NUM_TERMS-1:0] term_invert_in,
   input wire logic [SRC_BITS-1:0] raw_input_bits_in,
   input wire logic [SRC_BITS-1:0] virtual_input_bits_in,
   input wire logic [SRC_BITS-1:0] output_condition_term_in,
   input wire logic [SRC_BITS-1:0] alarm_condition_term_in,
   input wire logic [SRC_BITS-1:0] internal_state_term_in,
   input wire logic [2:0] engine_phase_in,
   input wire logic [SRC_BITS-1:0] analog_threshold_term_in,
   input wire logic [NUM_OUTPUTS*`BCC_FUNC_W-1:0] output_function_in,
   output logic result_out,
   output logic [NUM_OUTPUTS-1:0] logic_result_output_function_out
);
   // refused at elaboration: slot fields and the 8-bit index need these bounds
   if (NUM_TERMS < 1 || NUM_TERMS > `BCC_MAX_TERMS) begin : g_bad_terms
      $error("term count out of range");
   end
   if (SRC_BITS < 256) begin : g_bad_src
      $error("source vectors must cover the 8-bit index");
   end
   if (NUM_OUTPUTS < 1) begin : g_bad_outputs
      $error("at least one output is needed");
   end

   // pins are asynchronous: two stages before any use
   logic [SRC_BITS-1:0] pin_meta;
   logic [SRC_BITS-1:0] pin_sync;
   logic [SRC_BITS-1:0] next_pin_meta;
   logic [SRC_BITS-1:0] next_pin_sync;
   always_comb begin
      next_pin_meta = raw_input_bits_in;
      next_pin_sync = pin_meta;
   end
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= next_pin_meta;
         pin_sync <= next_pin_sync;
      end
   end

   // physical and virtual inputs share one index space
   logic [SRC_BITS-1:0] input_condition_term;
   logic [SRC_BITS-1:0] state_vec;
   always_comb begin
      input_condition_term = pin_sync | virtual_input_bits_in;
      state_vec = internal_state_term_in;
      // engine phases drive a one-hot group at consecutive indices
      for (int p = 0; p < 7; p++) begin
         state_vec[`BCC_STATE_ENGINE_BASE + p] = (engine_phase_in == 3'(p));
      end
   end

   logic [NUM_TERMS-1:0] term_used;
   logic [NUM_TERMS-1:0] term_value;
   genvar g;
   generate
      for (g = 0; g < NUM_TERMS; g++) begin : g_term
         logic [2:0] cls;
         assign cls = term_enable_in[g] ? term_class_in[g*`BCC_SRC_W +: `BCC_SRC_W]
                                        : `BCC_SRC_NONE;
         bcc_term_select #(.SRC_BITS(SRC_BITS)) u_sel (
            .class_in(cls),
            .index_in(term_index_in[g*`BCC_SEL_W +: `BCC_SEL_W]),
            .invert_in(term_invert_in[g]),
            .input_bits_in(input_condition_term),
            .output_bits_in(output_condition_term_in),
            .alarm_bits_in(alarm_condition_term_in),
            .state_bits_in(state_vec),
            .thresh_bits_in(analog_threshold_term_in),
            .used_out(term_used[g]),
            .value_out(term_value[g])
         );
      end
   endgenerate

   logic result;
   logic [NUM_OUTPUTS-1:0] dout;
   logic next_result;
   logic [NUM_OUTPUTS-1:0] next_dout;
   always_comb begin
      // unused slots count as true for AND and false for OR
      if (bcc_mode_t'(mode_or_in) == BCC_MODE_OR) begin
         next_result = |(term_value & term_used);
      end else begin
         next_result = &(term_value | ~term_used);
      end
      for (int o = 0; o < NUM_OUTPUTS; o++) begin
         next_dout[o] = (output_function_in[o*`BCC_FUNC_W +: `BCC_FUNC_W]
                         == `BCC_FUNC_LOGIC_RESULT) && next_result;
      end
   end
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         result <= `BCC_RESULT_RESET;
         dout <= '0;
      end else begin
         result <= next_result;
         dout <= next_dout;
      end
   end
   assign result_out = result;
   assign logic_result_output_function_out = dout;
endmodule : bcc_combiner

// ==== bcc_combiner_asserts.sv ====
// Purpose: port checks for bcc_combiner
// Assumes: single-term checks look at slot 0 only
// Notes: raw pins left out, their sync delay hides the cause
module bcc_combiner_chk #(
   parameter int NUM_TERMS = 30, NUM_OUTPUTS = 16, SRC_BITS = 256
) (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic mode_or_in,
   input wire logic [NUM_TERMS-1:0] term_enable_in,
   input wire logic [NUM_TERMS*3-1:0] term_class_in,
   input wire logic [NUM_TERMS*8-1:0] term_index_in,
   input wire logic [NUM_TERMS-1:0] term_invert_in,
   input wire logic [SRC_BITS-1:0] output_condition_term_in,
   input wire logic [2:0] engine_phase_in,
   input wire logic [NUM_OUTPUTS*4-1:0] output_function_in,
   input wire logic result_out,
   input wire logic [NUM_OUTPUTS-1:0] logic_result_output_function_out
);
   default clocking dc @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   wire one = term_enable_in == NUM_TERMS'(1);
   wire [2:0] cl = term_class_in[2:0];
   wire [7:0] ix = term_index_in[7:0];
   property p_ae; !mode_or_in && term_enable_in == '0 |=> result_out; endproperty
   a_ae: assert property (p_ae) else $error("and of no terms");
   property p_oe; mode_or_in && term_enable_in == '0 |=> !result_out; endproperty
   a_oe: assert property (p_oe) else $error("or of no terms");
   property p_nu; one && (cl == 3'h0 || cl > 3'h5) |=> result_out == !$past(mode_or_in); endproperty
   a_nu: assert property (p_nu) else $error("unused slot");
   property p_so;
      one && cl == 3'h2 |=> result_out == $past(output_condition_term_in[ix] ^ term_invert_in[0]);
   endproperty
   a_so: assert property (p_so) else $error("term select");
   property p_en;
      one && cl == 3'h4 && engine_phase_in != 3'h7 && ix == 8'h23 + 8'(engine_phase_in)
         |=> result_out != $past(term_invert_in[0]);
   endproperty
   a_en: assert property (p_en) else $error("engine phase");
   property p_fo; output_function_in[3:0] == 4'h3 |=> logic_result_output_function_out[0] == result_out; endproperty
   a_fo: assert property (p_fo) else $error("output follow");
   property p_fz; output_function_in[7:4] != 4'h3 |=> !logic_result_output_function_out[1]; endproperty
   a_fz: assert property (p_fz) else $error("output not logic");
   property p_md;
      term_enable_in == '0 ##1 term_enable_in == '0 && $changed(mode_or_in) |=> $changed(result_out);
   endproperty
   a_md: assert property (p_md) else $error("mode change");
   c_en: cover property (one && cl == 3'h4 ##1 result_out);
   c_iv: cover property (one && term_invert_in[0] ##1 result_out);
   c_all: cover property (term_enable_in == '1 ##1 result_out);
endmodule : bcc_combiner_chk
bind bcc_combiner bcc_combiner_chk #(.NUM_TERMS(NUM_TERMS), .NUM_OUTPUTS(NUM_OUTPUTS),
   .SRC_BITS(SRC_BITS)) u_chk (.*);

// ==== bcc_combiner_tb.sv ====
// Purpose: directed bench for bcc_combiner
// Assumes: physical pins stay low except in the pin scenario
// Notes: each check lands one cycle after its change, except raw pin changes, which show three edges later
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
      $display("CHECK FAILED %0t result", $time); end end
   logic clk_sys_in = 1'b0, reset_n_in = 1'b0, mode_or_in = 1'b0;
   logic [29:0] term_enable_in = '0, term_invert_in = '0;
   logic [89:0] term_class_in = '0;
   logic [239:0] term_index_in = '0;
   logic [255:0] raw_input_bits_in = '0, virtual_input_bits_in = 256'h20;
   logic [255:0] output_condition_term_in = 256'h20, alarm_condition_term_in = 256'h20;
   logic [255:0] internal_state_term_in = 256'h20, analog_threshold_term_in = 256'h20;
   logic [2:0] engine_phase_in = 3'h7;
   logic [63:0] output_function_in = 64'h23;
   logic result_out;
   logic [15:0] logic_result_output_function_out;
   int err_count = 0, checks = 0, cyc = 0;
   bcc_combiner dut (.*);
   always #10 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 200) begin
         err_count++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic e);
      @(posedge clk_sys_in);
      #1;
      `CHK(result_out, e)
      `CHK(logic_result_output_function_out, {15'h0, e})
   endtask : chk
   task automatic set0(input logic [2:0] c, input logic [7:0] i, input logic v);
      term_enable_in = 30'h1;
      term_class_in[2:0] = c;
      term_index_in[7:0] = i;
      term_invert_in[0] = v;
   endtask : set0
   task automatic t_empty();
      chk(1'b1);
      mode_or_in = 1'b1;
      chk(1'b0);
   endtask : t_empty
   task automatic t_sel();
      for (int k = 0; k < 16; k++) begin
         set0(3'(k / 2), 8'h05, 1'(k));
         chk((k > 1 && k < 12) ? !1'(k) : 1'b0);
      end
   endtask : t_sel
   task automatic t_eng();
      mode_or_in = 1'b0;
      for (int p = 0; p < 14; p++) begin
         engine_phase_in = 3'(p / 2);
         set0(3'h4, 8'h23 + 8'(p / 2) + 8'(p % 2), 1'b0);
         chk(!1'(p));
      end
   endtask : t_eng
   task automatic t_mix();
      for (int g = 0; g < 30; g++) begin
         term_class_in[g*3+:3] = 3'h2;
         term_index_in[g*8+:8] = 8'(g + 8);
      end
      term_enable_in = '1;
      output_condition_term_in[37:8] = 30'h1fff_ffff;
      chk(1'b0);
      term_invert_in = 30'h2000_0000;
      chk(1'b1);
      mode_or_in = 1'b1;
      output_condition_term_in[37:8] = '0;
      chk(1'b1);
      term_invert_in = '0;
      chk(1'b0);
   endtask : t_mix
   // physical pins pass two sync stages, so the result trails by three edges
   task automatic t_pin();
      mode_or_in = 1'b1;
      term_invert_in = '0;
      set0(3'h1, 8'h06, 1'b0);
      raw_input_bits_in[6] = 1'b1;
      chk(1'b0);
      chk(1'b0);
      chk(1'b1);
      raw_input_bits_in[6] = 1'b0;
      chk(1'b1);
      chk(1'b1);
      chk(1'b0);
   endtask : t_pin
   initial begin
      repeat (3) @(posedge clk_sys_in);
      #1;
      reset_n_in = 1'b1;
      t_empty();
      t_sel();
      t_eng();
      t_mix();
      t_pin();
      end_sim();
   end
endmodule : tb

// ==== bcc_pkg.sv ====
// Purpose: types for the boolean condition combiner
// Assumes: bcc_regs.svh
// Notes: mode and source class enumerations
`include "bcc_regs.svh"
package bcc_pkg;
   typedef enum logic {BCC_MODE_AND, BCC_MODE_OR} bcc_mode_t;
   typedef enum logic [2:0] {
      BCC_CLS_NONE = `BCC_SRC_NONE,
      BCC_CLS_INPUT = `BCC_SRC_INPUT,
      BCC_CLS_OUTPUT = `BCC_SRC_OUTPUT,
      BCC_CLS_ALARM = `BCC_SRC_ALARM,
      BCC_CLS_STATE = `BCC_SRC_STATE,
      BCC_CLS_THRESH = `BCC_SRC_THRESH
   } bcc_src_t;
   typedef enum logic [2:0] {
      BCC_ENG_STANDBY, BCC_ENG_STARTING, BCC_ENG_LOW_SPEED, BCC_ENG_DELAY,
      BCC_ENG_READY, BCC_ENG_COOLING, BCC_ENG_ARREST
   } bcc_engine_phase_t;
endpackage : bcc_pkg

// ==== bcc_regs.svh ====
// Purpose: constants for the boolean condition combiner
// Assumes: included by bare name from package and modules
// Notes: source classes select which status vector a term reads
`ifndef BCC_REGS_SVH
`define BCC_REGS_SVH
`define BCC_MAX_TERMS 30
`define BCC_SEL_W 8
`define BCC_SRC_W 3
`define BCC_FUNC_W 4
`define BCC_SRC_NONE 3'h0
`define BCC_SRC_INPUT 3'h1
`define BCC_SRC_OUTPUT 3'h2
`define BCC_SRC_ALARM 3'h3
`define BCC_SRC_STATE 3'h4
`define BCC_SRC_THRESH 3'h5
`define BCC_FUNC_LOGIC_RESULT 4'h3
`define BCC_STATE_ENGINE_BASE 8'h23
`define BCC_RESULT_RESET 1'b0
`endif

// ==== bcc_term_select.sv ====
// Purpose: pick one term's source bit and apply its invert setting
// Assumes: source vectors are synchronous to clk_sys_in
// Notes: pure combinational; an unknown class clears used_out so the combiner treats the slot as neutral
`include "bcc_regs.svh"
module bcc_term_select
   import bcc_pkg::*;
#(
   parameter int SRC_BITS = 256
) (
   input wire logic [2:0] class_in,
   input wire logic [`BCC_SEL_W-1:0] index_in,
   input wire logic invert_in,
   input wire logic [SRC_BITS-1:0] input_bits_in,
   input wire logic [SRC_BITS-1:0] output_bits_in,
   input wire logic [SRC_BITS-1:0] alarm_bits_in,
   input wire logic [SRC_BITS-1:0] state_bits_in,
   input wire logic [SRC_BITS-1:0] thresh_bits_in,
   output logic used_out,
   output logic value_out
);
   logic raw;
   always_comb begin
      raw = 1'b0;
      used_out = 1'b1;
      unique case (bcc_src_t'(class_in))
         BCC_CLS_INPUT: raw = input_bits_in[index_in];
         BCC_CLS_OUTPUT: raw = output_bits_in[index_in];
         BCC_CLS_ALARM: raw = alarm_bits_in[index_in];
         BCC_CLS_STATE: raw = state_bits_in[index_in];
         BCC_CLS_THRESH: raw = thresh_bits_in[index_in];
         default: used_out = 1'b0;
      endcase
      value_out = raw ^ invert_in;
   end
endmodule : bcc_term_select
